// File: cdfs_pkg.sv
// Shared constants for the compressed_word_port DMA and frame-sync glue.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package cdfs_pkg;
    // ****************************************************************
    // Sizes and levels
    // ****************************************************************
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 128;
    localparam int LVL_W = 8;
    localparam logic [LVL_W-1:0] LVL_QUARTER = 8'h20;
    localparam logic [LVL_W-1:0] LVL_3QUARTER = 8'h60;
    localparam logic [LVL_W-1:0] LVL_FULL = 8'h80;
    localparam logic [WORD_W-1:0] TERM_WORD = 32'hffffffff;
    localparam int MASK_W = 16;
    localparam int BIT_NB = 13;
    localparam int BIT_QTR = 6;
    localparam int BIT_VS = 0;
    localparam int BIT_3Q = 1;
    localparam logic [MASK_W-1:0] MASK_RST = 16'h0000;
    localparam int DLY_W = 8;
    localparam logic [DLY_W-1:0] VS_DELAY = 8'h04;
    // ****************************************************************
    // Wishbone register map (byte addresses)
    // ****************************************************************
    localparam int ADR_W = 4;
    localparam logic [ADR_W-1:0] A_STATUS = 4'h0;
    localparam logic [ADR_W-1:0] A_MASK = 4'h4;
    localparam logic [ADR_W-1:0] A_CTRL = 4'h8;
    localparam logic [ADR_W-1:0] A_DATA = 4'hc;
    localparam int ST_SOF = 0;
    localparam int ST_EOF = 1;
    localparam int ST_LOST = 2;
    localparam int ST_W = 3;
    localparam int C_CLRHOLD = 0;
    localparam int C_SRCSEL = 1;
    localparam int C_FIELDQ = 2;
    localparam int C_W = 3;
endpackage

// File: cdfs_if.sv
// Interface joining the compressor end and the host glue end.
// Assumes both ends share clk_i; no clocking block.
`timescale 1ns/1ps
interface cdfs_if;
    import cdfs_pkg::*;
    logic transfer_request;
    logic [WORD_W-1:0] compressed_word_port;
    logic word_read;
    logic compressed_word_port_not_busy;
    logic fifo_quarter_flag;
    logic compressor_frame_sync;
    logic fifo_level_request;
    logic stall;
    logic pixel_input_strobe;
    logic [MASK_W-1:0] request_mask;
    logic [MASK_W-1:0] level_mask;
    logic mask_we;
    modport dev (
        output transfer_request, compressed_word_port, compressed_word_port_not_busy,
        output fifo_quarter_flag, compressor_frame_sync,
        output fifo_level_request, pixel_input_strobe,
        input word_read, stall, request_mask, level_mask, mask_we
    );
    modport host (
        input transfer_request, compressed_word_port, compressed_word_port_not_busy,
        input fifo_quarter_flag, compressor_frame_sync,
        input fifo_level_request, pixel_input_strobe,
        output word_read, stall, request_mask, level_mask, mask_we
    );
endinterface

// File: cdfs_host.sv
// Host glue: Wishbone registers, DMA reader, frame interrupts, hold.
// Assumes the compressor end on the same clock; sync pins are foreign.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cdfs_host
    import cdfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    cdfs_if.host lnk,
    input wire logic incoming_frame_sync_i,
    input wire logic field_odd_i,
    input wire logic pixel_ready_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [WORD_W-1:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [WORD_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic [WORD_W-1:0] dma_data_o,
    output logic dma_valid_o
);
    // ****************************************************************
    // Pin synchronisers (three stages, second and third agree)
    // ****************************************************************
    logic [2:0] incoming_frame_sync_reg, fld_reg;
    logic incoming_frame_sync_st_reg, fld_st_reg, incoming_frame_sync_prev_reg;
    logic cvs_prev_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            incoming_frame_sync_reg <= 3'h0;
            fld_reg <= 3'h0;
        end else begin
            incoming_frame_sync_reg <= {incoming_frame_sync_reg[1:0], incoming_frame_sync_i};
            fld_reg <= {fld_reg[1:0], field_odd_i};
        end
    end
    wire incoming_frame_sync_agree = (incoming_frame_sync_reg[1] == incoming_frame_sync_reg[2]);
    wire fld_agree = (fld_reg[1] == fld_reg[2]);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            incoming_frame_sync_st_reg <= 1'b0;
            fld_st_reg <= 1'b0;
            incoming_frame_sync_prev_reg <= 1'b0;
            cvs_prev_reg <= 1'b1;
        end else begin
            if (incoming_frame_sync_agree)
                incoming_frame_sync_st_reg <= incoming_frame_sync_reg[2];
            if (fld_agree)
                fld_st_reg <= fld_reg[2];
            incoming_frame_sync_prev_reg <= incoming_frame_sync_st_reg;
            cvs_prev_reg <= lnk.compressor_frame_sync;
        end
    end
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [ST_W-1:0] status_reg, status_next, irqmask_reg;
    logic [C_W-1:0] ctrl_reg;
    logic [MASK_W-1:0] rmask_reg, lmask_reg;
    logic mask_we_reg, hold_reg, last_sof_reg;
    logic [WORD_W-1:0] last_word_reg;
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wire wr_status = wb_wr & (wb_adr_i == A_STATUS);
    wire wr_mask = wb_wr & (wb_adr_i == A_MASK);
    wire wr_ctrl = wb_wr & (wb_adr_i == A_CTRL);
    wire wr_rmask = wb_wr & (wb_adr_i == A_DATA);
    // Start-of-frame gated by odd field; end by compressor sync edge
    wire sof_ev = incoming_frame_sync_st_reg & ~incoming_frame_sync_prev_reg
                  & (fld_st_reg | ~ctrl_reg[C_FIELDQ]);
    wire eof_ev = lnk.compressor_frame_sync & ~cvs_prev_reg;
    wire lost_ev = sof_ev & last_sof_reg;
    wire [ST_W-1:0] ev = {lost_ev, eof_ev, sof_ev};
    // Set wins over write-one-to-clear
    assign status_next = (status_reg & ~(wr_status ? wb_dat_i[ST_W-1:0]
                         : {ST_W{1'b0}})) | ev;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= {ST_W{1'b0}};
            irqmask_reg <= {ST_W{1'b0}};
            ctrl_reg <= {C_W{1'b0}};
            last_sof_reg <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_o <= |(status_next & irqmask_reg);
            if (wr_mask)
                irqmask_reg <= wb_dat_i[ST_W-1:0];
            if (wr_ctrl)
                ctrl_reg <= wb_dat_i[C_W-1:0];
            else
                ctrl_reg[C_CLRHOLD] <= 1'b0;
            if (sof_ev)
                last_sof_reg <= 1'b1;
            else if (eof_ev)
                last_sof_reg <= 1'b0;
        end
    end
    // Mask word: low half request mask, high half level mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rmask_reg <= MASK_RST;
            lmask_reg <= MASK_RST;
            mask_we_reg <= 1'b0;
        end else begin
            mask_we_reg <= wr_rmask;
            if (wr_rmask) begin
                rmask_reg <= wb_dat_i[MASK_W-1:0];
                lmask_reg <= wb_dat_i[WORD_W-1:MASK_W];
            end
        end
    end
    // ****************************************************************
    // Hold and stall
    // ****************************************************************
    // Hold chosen by sync edge, or level request when selected
    wire hold_src = ctrl_reg[C_SRCSEL] ? lnk.fifo_level_request
                                       : hold_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg <= 1'b0;
            lnk.stall <= 1'b1;
        end else begin
            if (eof_ev)
                hold_reg <= 1'b1;
            else if (wr_ctrl & wb_dat_i[C_CLRHOLD])
                hold_reg <= 1'b0;
            lnk.stall <= hold_src | ~pixel_ready_i
                         | (~ctrl_reg[C_SRCSEL]
                            & lnk.fifo_level_request);
        end
    end
    // ****************************************************************
    // DMA reader and programmed drain
    // ****************************************************************
    // One read per request cycle with word_read low; device has the word ready
    wire pio_rd = wb_req & ~wb_we_i & (wb_adr_i == A_DATA);
    wire dma_rd = lnk.transfer_request & ~lnk.word_read;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lnk.word_read <= 1'b0;
            dma_data_o <= {WORD_W{1'b0}};
            dma_valid_o <= 1'b0;
            last_word_reg <= {WORD_W{1'b0}};
        end else begin
            lnk.word_read <= dma_rd | pio_rd;
            dma_valid_o <= dma_rd;
            if (dma_rd)
                dma_data_o <= lnk.compressed_word_port;
            if (pio_rd)
                last_word_reg <= lnk.compressed_word_port;
        end
    end
    assign lnk.request_mask = rmask_reg;
    assign lnk.level_mask = lmask_reg;
    assign lnk.mask_we = mask_we_reg;
    // ****************************************************************
    // Wishbone read and ack
    // ****************************************************************
    wire [WORD_W-1:0] rd_mux =
        (wb_adr_i == A_STATUS) ? {{(WORD_W-ST_W){1'b0}}, status_reg} :
        (wb_adr_i == A_MASK) ? {{(WORD_W-ST_W){1'b0}}, irqmask_reg} :
        (wb_adr_i == A_CTRL) ? {{(WORD_W-C_W-3){1'b0}}, incoming_frame_sync_st_reg,
                                cvs_prev_reg, hold_reg, ctrl_reg} :
        (wb_adr_i == A_DATA) ? lnk.compressed_word_port : {WORD_W{1'b0}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {WORD_W{1'b0}};
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= rd_mux;
        end
    end
endmodule

// File: cdfs_dev.sv
// Compressor end: output FIFO, request logic, frame sync, stall.
// Assumes the host glue on the same clock through cdfs_if.
`timescale 1ns/1ps
module cdfs_dev
    import cdfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    cdfs_if.dev lnk,
    input wire logic frame_start_i,
    input wire logic [WORD_W-1:0] code_word_i,
    input wire logic code_valid_i,
    input wire logic pipe_empty_i,
    output logic frame_active_o
);
    // ****************************************************************
    // Word store
    // ****************************************************************
    logic [WORD_W-1:0] mem [FIFO_DEPTH];
    logic [LVL_W-2:0] wp_reg, rp_reg;
    logic [LVL_W-1:0] lvl_reg;
    logic started_reg, vs_reg, lvlreq_reg;
    logic [MASK_W-1:0] rmask_reg, lmask_reg;
    logic [DLY_W-1:0] dly_reg;
    wire push = code_valid_i & ~lnk.stall & (lvl_reg != LVL_FULL);
    wire pop = lnk.word_read & (lvl_reg != 8'h00);
    wire quarter = (lvl_reg >= LVL_QUARTER);
    wire three_q = (lvl_reg >= LVL_3QUARTER);
    wire nb = (lvl_reg != 8'h00);
    always_ff @(posedge clk_i) begin
        if (push)
            mem[wp_reg] <= code_word_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= 7'h00;
            rp_reg <= 7'h00;
            lvl_reg <= 8'h00;
        end else begin
            if (push)
                wp_reg <= wp_reg + 7'h01;
            if (pop)
                rp_reg <= rp_reg + 7'h01;
            lvl_reg <= lvl_reg + {7'h00, push} - {7'h00, pop};
        end
    end
    // ****************************************************************
    // Request and flags
    // ****************************************************************
    // Request ends when drained to quarter with pipeline empty
    wire below_stop = pipe_empty_i & ~(lvl_reg > LVL_QUARTER);
    wire req_cond = started_reg & nb & ~pop
        & (~rmask_reg[BIT_NB] | nb)
        & (~rmask_reg[BIT_QTR] | quarter) & ~below_stop;
    wire lvl_cond = (lmask_reg[BIT_VS] & vs_reg)
                    | (lmask_reg[BIT_3Q] & three_q);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            started_reg <= 1'b0;
            rmask_reg <= MASK_RST;
            lmask_reg <= MASK_RST;
            lnk.transfer_request <= 1'b0;
            lnk.fifo_level_request <= 1'b0;
        end else begin
            if (quarter)
                started_reg <= 1'b1;
            if (lnk.mask_we) begin
                rmask_reg <= lnk.request_mask;
                lmask_reg <= lnk.level_mask;
            end
            lnk.transfer_request <= req_cond;
            lnk.fifo_level_request <= lvl_cond;
        end
    end
    assign lnk.compressed_word_port = nb ? mem[rp_reg] : TERM_WORD;
    assign lnk.compressed_word_port_not_busy = nb;
    assign lnk.fifo_quarter_flag = quarter;
    assign lnk.pixel_input_strobe = frame_active_o & ~lnk.stall;
    // ****************************************************************
    // Frame sync output (high between frames, 1 = sync active)
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vs_reg <= 1'b1;
            dly_reg <= {DLY_W{1'b0}};
            frame_active_o <= 1'b0;
        end else if (frame_start_i & ~frame_active_o & ~lnk.stall) begin
            dly_reg <= VS_DELAY;
            frame_active_o <= 1'b1;
        end else if (dly_reg != 8'h00) begin
            dly_reg <= dly_reg - 8'h01;
            if (dly_reg == 8'h01)
                vs_reg <= 1'b0;
        end else if (frame_active_o & pipe_empty_i & ~vs_reg) begin
            vs_reg <= 1'b1;
            frame_active_o <= 1'b0;
        end
    end
    assign lnk.compressor_frame_sync = vs_reg;
endmodule

// File: cdfs_chk.sv
// Checker for the link between the compressor and host glue ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cdfs_chk
    import cdfs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic transfer_request,
    input wire logic [WORD_W-1:0] compressed_word_port,
    input wire logic word_read,
    input wire logic compressed_word_port_not_busy,
    input wire logic fifo_quarter_flag,
    input wire logic compressor_frame_sync,
    input wire logic fifo_level_request,
    input wire logic stall,
    input wire logic pixel_input_strobe,
    input wire logic [MASK_W-1:0] request_mask,
    input wire logic [MASK_W-1:0] level_mask,
    input wire logic mask_we
);
    // ****************
    // Link properties
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    req_mask_a: assert property (
        $rose(transfer_request) |->
        $past(request_mask[BIT_NB] & request_mask[BIT_QTR]))
        else $error("request rose with request mask clear");
    req_quarter_a: assert property (
        $rose(transfer_request) |-> $past(fifo_quarter_flag))
        else $error("request rose below quarter level");
    req_word_a: assert property (
        transfer_request |->
        compressed_word_port_not_busy && compressed_word_port != TERM_WORD)
        else $error("request without a word in the port");
    read_pulse_a: assert property (
        word_read |=> !word_read)
        else $error("word read wider than one cycle");
    req_stop_a: assert property (
        $fell(fifo_quarter_flag) |-> ##[1:2] !transfer_request)
        else $error("request kept up below quarter level");
    hold_sync_a: assert property (
        $rose(compressor_frame_sync) |-> ##[1:2] stall)
        else $error("no stall after frame sync");
    level_sync_a: assert property (
        level_mask[BIT_VS] && compressor_frame_sync && !mask_we
        |-> ##[1:2] fifo_level_request)
        else $error("level request missing on sync flag");
    sync_delay_a: assert property (
        $fell(compressor_frame_sync) |->
        $past(pixel_input_strobe, 4) && !$past(pixel_input_strobe, 5))
        else $error("frame sync dropped off its delay");
    stall_strobe_a: assert property (
        stall [*2] |-> !pixel_input_strobe)
        else $error("pixel strobe while stalled");
    level_stall_a: assert property (
        fifo_level_request |=> stall)
        else $error("level request did not stall");
endmodule

// File: test_compressed_word_port_dma_frame_sync_control.sv
// Bench driving both ends: Wishbone host side and compressor feed.
// Assumes the package, interface, both ends and checker compiled first.
`timescale 1ns/1ps
module test_compressed_word_port_dma_frame_sync_control;
    import cdfs_pkg::*;
    // ****************
    // Wiring
    // ****************
    logic clk_i, rst_i, sync_in, fodd, we, cyc, stb, fst, cv, pe;
    logic [3:0] adr;
    logic [31:0] wd, cw, d;
    logic [31:0] wb_dat, dma_d;
    logic ack, irq, dma_v, fact, prdy;
    int err_count, compares, rd_n, cyc_n, i;
    localparam logic [31:0] BASE = 32'h00a50000;
    cdfs_if lnk();
    cdfs_host u_cdfs_host(.clk_i, .rst_i, .lnk(lnk.host),
        .incoming_frame_sync_i(sync_in), .field_odd_i(fodd),
        .pixel_ready_i(prdy), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(wb_dat), .wb_ack_o(ack), .irq_o(irq),
        .dma_data_o(dma_d), .dma_valid_o(dma_v));
    cdfs_dev u_cdfs_dev(.clk_i, .rst_i, .lnk(lnk.dev),
        .frame_start_i(fst), .code_word_i(cw), .code_valid_i(cv),
        .pipe_empty_i(pe), .frame_active_o(fact));
    cdfs_chk u_cdfs_chk(.clk_i, .rst_i,
        .transfer_request(lnk.transfer_request),
        .compressed_word_port(lnk.compressed_word_port),
        .word_read(lnk.word_read), .compressed_word_port_not_busy(lnk.compressed_word_port_not_busy),
        .fifo_quarter_flag(lnk.fifo_quarter_flag),
        .compressor_frame_sync(lnk.compressor_frame_sync),
        .fifo_level_request(lnk.fifo_level_request), .stall(lnk.stall),
        .pixel_input_strobe(lnk.pixel_input_strobe),
        .request_mask(lnk.request_mask), .level_mask(lnk.level_mask),
        .mask_we(lnk.mask_we));
    // ****************
    // Tasks
    // ****************
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, got);
        end
    endtask
    // Slave timing is never assumed; only the watchdog ends a wait
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= v;
        @(posedge clk_i iff ack === 1'b1);
        d = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulse_sync(input logic odd);
        @(posedge clk_i);
        fodd <= odd;
        sync_in <= 1'b1;
        repeat (4) @(posedge clk_i);
        sync_in <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    // ****************
    // Clock, DMA sink, watchdog
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (dma_v === 1'b1) begin
            check("dma word", dma_d, BASE + rd_n);
            rd_n++;
        end
        if (cyc_n == 20000) begin
            err_count++;
            conclude();
        end
    end
    // ****************
    // Sequence
    // ****************
    initial begin
        {rst_i, sync_in, fodd, we, cyc, stb, fst, cv, pe} = 9'h100;
        prdy = 1'b1;
        adr = 4'h0;
        wd = 32'h0;
        cw = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, A_STATUS, 32'h0);
        check("status", d, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        wb(1'b0, 4'h2, 32'h0);
        check("unmapped", d, 32'h0);
        $display("test reset done");
        wb(1'b1, A_DATA, 32'h00022040);
        wb(1'b1, A_MASK, 32'h7);
        wb(1'b1, A_CTRL, 32'h4);
        pulse_sync(1'b0);
        wb(1'b0, A_STATUS, 32'h0);
        check("even field", d[2:0], 32'h0);
        pulse_sync(1'b1);
        wb(1'b0, A_STATUS, 32'h0);
        check("odd field", d[2:0], 32'h1);
        check("irq up", {31'h0, irq}, 32'h1);
        pulse_sync(1'b1);
        wb(1'b0, A_STATUS, 32'h0);
        check("lost sync", d[2:0], 32'h5);
        wb(1'b1, A_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        check("irq masked", {31'h0, irq}, 32'h0);
        wb(1'b1, A_MASK, 32'h7);
        wb(1'b1, A_STATUS, 32'h7);
        wb(1'b0, A_STATUS, 32'h0);
        check("cleared", d[2:0], 32'h0);
        $display("test interrupts done");
        wb(1'b1, A_CTRL, 32'h5);
        wb(1'b0, A_CTRL, 32'h0);
        check("hold off", {31'h0, d[3]}, 32'h0);
        fst <= 1'b1;
        repeat (8) @(posedge clk_i);
        check("frame active", {31'h0, fact}, 32'h1);
        check("sync low", {31'h0, lnk.compressor_frame_sync}, 32'h0);
        // Stall never rises here, so no pushed word is dropped
        for (i = 0; i < 40; i++) begin
            cw <= BASE + i;
            cv <= 1'b1;
            @(posedge clk_i);
        end
        check("no stall", {31'h0, lnk.stall}, 32'h0);
        cv <= 1'b0;
        pe <= 1'b1;
        repeat (300) @(posedge clk_i);
        check("hold stall", {31'h0, lnk.stall}, 32'h1);
        check("quarter kept", {31'h0, lnk.fifo_quarter_flag}, 32'h1);
        check("dma ran", {31'h0, rd_n > 0}, 32'h1);
        check("left on chip", {31'h0, lnk.compressed_word_port_not_busy}, 32'h1);
        for (i = 0; i < 60; i++) begin
            wb(1'b0, A_DATA, 32'h0);
            if (d === TERM_WORD)
                break;
            check("drained word", d, BASE + rd_n);
            rd_n++;
        end
        check("word total", rd_n, 32'd40);
        $display("test transfer done");
        fst <= 1'b0;
        repeat (40) @(posedge clk_i);
        wb(1'b0, A_STATUS, 32'h0);
        check("end of frame", d[2:0], 32'h2);
        wb(1'b0, A_CTRL, 32'h0);
        check("hold on sync", {30'h0, d[4:3]}, 32'h3);
        wb(1'b1, A_DATA, 32'h00012040);
        wb(1'b1, A_CTRL, 32'h3);
        repeat (3) @(posedge clk_i);
        check("level stall", {31'h0, lnk.stall}, 32'h1);
        wb(1'b1, A_DATA, 32'h00002040);
        repeat (3) @(posedge clk_i);
        check("remasked", {31'h0, lnk.stall}, 32'h0);
        prdy <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("pixel wait", {31'h0, lnk.stall}, 32'h1);
        $display("test frame end done");
        conclude();
    end
endmodule
